/* inc/pwlk_pkg.sv */
package pwlk_pkg;
  // ****************
  // opcodes
  // ****************
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_LOCKCL = 8'ha6;
  localparam logic [7:0] OP_PWRD   = 8'he7;
  localparam logic [7:0] OP_PWPROG = 8'he8;
  localparam logic [7:0] OP_PWUNLK = 8'he9;
  localparam logic [7:0] OP_CLRST  = 8'h30;
  localparam logic [7:0] OP_SWRST  = 8'hf0;
  // ****************
  // field positions and reset values
  // ****************
  localparam int          ASP_PWMODE_BIT = 2;
  localparam int          CR1_FREEZE_BIT = 1;
  localparam int          CR1_VOLSEL_BIT = 3;
  localparam logic [63:0] PW_ERASED      = 64'hffff_ffff_ffff_ffff;
  localparam logic [2:0]  BP_RST         = 3'h0;
  localparam logic [6:0]  BITS_INSTR     = 7'h08;
  localparam logic [6:0]  BITS_PW        = 7'h48;
  // ****************
  // timing
  // ****************
  localparam int          CLK_MHZ        = 125;
  localparam int          T_PROG_US      = 10;
  localparam int          T_LOCK_US      = 1;
  localparam int          RESET_RECOVERY_TIME_US       = 35;
  localparam int          PROG_CYC       = T_PROG_US * CLK_MHZ;
  localparam int          LOCK_CYC       = T_LOCK_US * CLK_MHZ;
  localparam int          RPH_CYC        = RESET_RECOVERY_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {PW_IDLE, PW_LOCK, PW_PROG, PW_UNLK, PW_FAIL, PW_RST} pwlk_state_t;
endpackage

/* logic/pwlk_core.sv */
`timescale 1ns/1ns
// What this block does
// - lock-clear command a6h clears the lock bit when its timed operation ends.
// - lock-clear is accepted only while the write enable latch is set.
// - lock-clear runs only if chip select rises right after eight bits.
// - busy flag high during lock-clear; on completion busy and latch drop.
// - status stays readable while a protection operation is busy.
// - password read e7h works only while asp bit 2 is one.
// - password shifts out low byte first, msb first, on falling clock.
// - password output repeats every 64 clocks while host keeps clocking.
// - password program e8h needs write enable and asp bit 2 one.
// - program runs only if select rises after bit 72; busy while running.
// - failed program raises program error; latch cleared at program end.
// - unlock e9h takes 64 password bits and must end exactly there.
// - unlock mismatch sets program error and leaves busy stuck high.
// - only clear-status, software reset or hard reset leave the stuck error.
// - unlock match sets the lock bit to one.
// - software reset f0h restores power-up state but keeps freeze, lock and the stored password.
// - software reset keeps the nonvolatile configuration select bits.
// - software reset clears block protect only if volatile and not frozen.
// - freeze clear and lock restore need a hard reset, not software reset.
// - software reset starts at select rise and lasts the recovery time.
module pwlk_core #(
  parameter int PROG_CYCLES = pwlk_pkg::PROG_CYC,
  parameter int LOCK_CYCLES = pwlk_pkg::LOCK_CYC,
  parameter int RPH_CYCLES  = pwlk_pkg::RPH_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       wel_set,
  input  wire logic [2:0] asp_in,
  input  wire logic       lock_por_val,
  input  wire logic       prog_fail,
  input  wire logic       freeze_set,
  input  wire logic       bp_wr,
  input  wire logic [2:0] bp_wdata,
  input  wire logic       volsel_in,
  input  wire logic       tb_prot_in,
  input  wire logic       tb_parm_in,
  output logic            so,
  output logic            so_oe,
  output logic            write_enable_latch,
  output logic            write_in_progress,
  output logic            program_error,
  output logic            persistent_protection_bit,
  output logic            freeze,
  output logic [2:0]      block_protect,
  output logic            protection_volatility_select,
  output logic            top_bottom_protect_select,
  output logic            top_bottom_parameter_select,
  output logic            in_reset
);
  // ****************
  // pin synchronisers and edges
  // ****************
  logic [1:0] cs_s_q, sck_s_q, si_s_q;
  logic       cs_d1_q, sck_d1_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s_q   <= 2'h3;
      sck_s_q  <= 2'h0;
      si_s_q   <= 2'h0;
      cs_d1_q  <= 1'h1;
      sck_d1_q <= 1'h0;
    end else begin
      cs_s_q   <= {cs_s_q[0], cs_n};
      sck_s_q  <= {sck_s_q[0], sck};
      si_s_q   <= {si_s_q[0], si};
      cs_d1_q  <= cs_s_q[1];
      sck_d1_q <= sck_s_q[1];
    end
  end
  wire cs_lo   = ~cs_s_q[1];
  wire cs_rise = cs_s_q[1] & ~cs_d1_q;
  wire sck_r   = cs_lo & sck_s_q[1] & ~sck_d1_q;
  wire sck_f   = cs_lo & ~sck_s_q[1] & sck_d1_q;
  wire si_b    = si_s_q[1];

  // ****************
  // frame shifter
  // ****************
  logic [6:0]  bcnt_q;
  logic [7:0]  op_q;
  logic [63:0] data_q;
  logic        ovf_q;
  wire         bcnt_full = (bcnt_q == 7'h7f);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bcnt_q <= 7'h0;
      op_q   <= 8'h0;
      data_q <= 64'h0;
      ovf_q  <= 1'h0;
    end else if (~cs_lo) begin
      bcnt_q <= 7'h0;
      ovf_q  <= 1'h0;
    end else if (sck_r) begin
      bcnt_q <= bcnt_full ? bcnt_q : bcnt_q + 7'h1;
      ovf_q  <= ovf_q | bcnt_full;
      if (bcnt_q < pwlk_pkg::BITS_INSTR) begin
        op_q <= {op_q[6:0], si_b};
      end else begin
        data_q <= {data_q[62:0], si_b};
      end
    end
  end
  // serial order is byte 0 first, msb first: byte-swap the shift image
  logic [63:0] pw_rx;
  for (genvar i = 0; i < 8; i++) begin : g_swap
    assign pw_rx[8*i +: 8] = data_q[8*(7-i) +: 8];
  end

  // ****************
  // command decode at select rise
  // ****************
  logic        wel_q, wip_q, perr_q, lock_q, frz_q, vol_q, tbp_q, tbm_q;
  logic [2:0]  bp_q;
  logic [63:0] pw_q;
  logic [31:0] tmr_q;
  pwlk_pkg::pwlk_state_t st_q;
  wire idle      = (st_q == pwlk_pkg::PW_IDLE);
  wire pw_open   = asp_in[pwlk_pkg::ASP_PWMODE_BIT];
  wire len8      = ~ovf_q & (bcnt_q == pwlk_pkg::BITS_INSTR);
  wire len72     = ~ovf_q & (bcnt_q == pwlk_pkg::BITS_PW);
  wire go_lock   = cs_rise & idle & len8 & wel_q
                   & (op_q == pwlk_pkg::OP_LOCKCL);
  wire go_prog   = cs_rise & idle & len72 & wel_q & pw_open
                   & (op_q == pwlk_pkg::OP_PWPROG);
  wire go_unlk   = cs_rise & idle & len72 & (op_q == pwlk_pkg::OP_PWUNLK);
  wire go_clr    = cs_rise & len8 & (op_q == pwlk_pkg::OP_CLRST)
                   & (idle | st_q == pwlk_pkg::PW_FAIL);
  wire go_swrst  = cs_rise & len8 & (op_q == pwlk_pkg::OP_SWRST);
  wire tmr_done  = (tmr_q == 32'h0);
  wire pw_match  = (pw_rx == pw_q);
  wire write_enable_cmd_hit  = cs_rise & idle & len8 & (op_q == pwlk_pkg::OP_WRITE_ENABLE_CMD);

  // ****************
  // operation sequencer
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= pwlk_pkg::PW_IDLE;
      tmr_q <= 32'h0;
    end else if (go_swrst) begin
      st_q  <= pwlk_pkg::PW_RST;
      tmr_q <= 32'(RPH_CYCLES - 1);
    end else begin
      unique case (st_q)
        pwlk_pkg::PW_IDLE: begin
          if (go_lock) begin
            st_q  <= pwlk_pkg::PW_LOCK;
            tmr_q <= 32'(LOCK_CYCLES - 1);
          end else if (go_prog | go_unlk) begin
            st_q  <= go_prog ? pwlk_pkg::PW_PROG : pwlk_pkg::PW_UNLK;
            tmr_q <= 32'(PROG_CYCLES - 1);
          end
        end
        pwlk_pkg::PW_UNLK: begin
          if (tmr_done) begin
            st_q <= pw_match ? pwlk_pkg::PW_IDLE : pwlk_pkg::PW_FAIL;
          end else begin
            tmr_q <= tmr_q - 32'h1;
          end
        end
        pwlk_pkg::PW_FAIL: begin
          if (go_clr) begin
            st_q <= pwlk_pkg::PW_IDLE;
          end
        end
        default: begin
          if (tmr_done) begin
            st_q <= pwlk_pkg::PW_IDLE;
          end else begin
            tmr_q <= tmr_q - 32'h1;
          end
        end
      endcase
    end
  end
  wire end_lock = (st_q == pwlk_pkg::PW_LOCK) & tmr_done;
  wire end_prog = (st_q == pwlk_pkg::PW_PROG) & tmr_done;
  wire end_unlk = (st_q == pwlk_pkg::PW_UNLK) & tmr_done;

  // ****************
  // recovery flag
  // ****************
  // registered so the pin carries no decode glitch; tracks the reset state one for one
  logic in_rst_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_rst_q <= 1'h0;
    end else begin
      in_rst_q <= go_swrst | ((st_q == pwlk_pkg::PW_RST) & ~tmr_done);
    end
  end

  // ****************
  // protection and status state
  // ****************
  // the lock power-on value is strapped in after release, never inside the reset branch
  logic por_done_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_done_q <= 1'h0;
      lock_q     <= 1'h0;
      frz_q      <= 1'h0;
      pw_q       <= pwlk_pkg::PW_ERASED;
      vol_q      <= 1'h0;
      tbp_q      <= 1'h0;
      tbm_q      <= 1'h0;
      bp_q       <= pwlk_pkg::BP_RST;
    end else begin
      por_done_q <= 1'h1;
      if (~por_done_q) begin
        lock_q <= lock_por_val;
        vol_q  <= volsel_in;
        tbp_q  <= tb_prot_in;
        tbm_q  <= tb_parm_in;
      end else if (end_lock) begin
        lock_q <= 1'h0;
      end else if (end_unlk & pw_match) begin
        lock_q <= 1'h1;
      end
      // freeze only sets here; a software reset never clears it
      if (freeze_set) begin
        frz_q <= 1'h1;
      end
      if (end_prog & ~prog_fail) begin
        pw_q <= pw_rx;
      end
      if (go_swrst & vol_q & ~frz_q) begin
        bp_q <= pwlk_pkg::BP_RST;
      end else if (bp_wr & ~frz_q) begin
        bp_q <= bp_wdata;
      end
    end
  end

  // ****************
  // status bits
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_q  <= 1'h0;
      wip_q  <= 1'h0;
      perr_q <= 1'h0;
    end else begin
      if (go_swrst | end_lock | end_prog) begin
        wel_q <= 1'h0;
      end else if (write_enable_cmd_hit | wel_set) begin
        wel_q <= 1'h1;
      end
      if (go_swrst | go_clr) begin
        perr_q <= 1'h0;
      end else if ((end_unlk & ~pw_match) | (end_prog & prog_fail)) begin
        perr_q <= 1'h1;
      end
      wip_q <= (go_lock | go_prog | go_unlk) ? 1'h1 :
               (go_swrst | go_clr | end_lock | end_prog | end_unlk) ?
               (end_unlk & ~pw_match & ~go_clr & ~go_swrst) : wip_q;
    end
  end

  // ****************
  // password read-out
  // ****************
  // bit index counts from the first falling edge after the opcode and wraps at 64
  logic [5:0] rd_idx_q;
  logic       so_q, oe_q;
  wire        rd_act = idle & pw_open & (op_q == pwlk_pkg::OP_PWRD)
                       & (ovf_q | bcnt_q >= pwlk_pkg::BITS_INSTR);
  wire [5:0]  rd_bit = {rd_idx_q[5:3], ~rd_idx_q[2:0]};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_idx_q <= 6'h0;
      so_q     <= 1'h0;
      oe_q     <= 1'h0;
    end else if (~cs_lo) begin
      rd_idx_q <= 6'h0;
      oe_q     <= 1'h0;
    end else if (sck_f & rd_act) begin
      so_q     <= pw_q[rd_bit];
      oe_q     <= 1'h1;
      rd_idx_q <= rd_idx_q + 6'h1;
    end
  end

  assign so                           = so_q;
  assign so_oe                        = oe_q;
  assign write_enable_latch           = wel_q;
  assign write_in_progress            = wip_q;
  assign program_error                = perr_q;
  assign persistent_protection_bit    = lock_q;
  assign freeze                       = frz_q;
  assign block_protect                = bp_q;
  assign protection_volatility_select = vol_q;
  assign top_bottom_protect_select    = tbp_q;
  assign top_bottom_parameter_select  = tbm_q;
  assign in_reset                     = in_rst_q;
endmodule

/* bench/pwlk_host.sv */
`timescale 1ns/1ns
// ****************
// spi host model, mode 0
// ****************
module pwlk_host (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // sck stands still outside frames; a 64 ns bit keeps it well under 133 mhz
  task automatic xfer(input logic [135:0] d, input int n, output logic [127:0] r);
    r = '0;
    @(negedge clk) cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si <= d[135-i];
      repeat (4) @(negedge clk);
      sck <= 1'b1;
      repeat (4) @(negedge clk);
      r = {r[126:0], so};
      sck <= 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (8) @(negedge clk);
  endtask
endmodule

/* bench/pwlk_core_sva.sv */
`timescale 1ns/1ns
// ****************
// protection checker
// ****************
module pwlk_core_sva #(
  parameter int PROG_CYCLES = 10,
  parameter int LOCK_CYCLES = 6,
  parameter int RPH_CYCLES  = 8
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [2:0] asp_in,
  input wire logic       so_oe,
  input wire logic       write_enable_latch,
  input wire logic       write_in_progress,
  input wire logic       program_error,
  input wire logic       persistent_protection_bit,
  input wire logic       freeze,
  input wire logic [2:0] block_protect,
  input wire logic       protection_volatility_select,
  input wire logic       top_bottom_protect_select,
  input wire logic       top_bottom_parameter_select,
  input wire logic       in_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // recovery length is counted, a repetition would need a literal count
  logic [15:0] rph_q;
  logic [15:0] rph_d;
  assign rph_d = in_reset ? rph_q + 16'h1 : 16'h0;
  always_ff @(posedge clk or posedge rst)
    if (rst) rph_q <= 16'h0;
    else rph_q <= rph_d;
  sequence s_op_done;
    $fell(write_in_progress) && !in_reset && !$past(program_error);
  endsequence
  property p_wel_drop; s_op_done |-> !write_enable_latch; endproperty
  a_wel_drop: assert property (p_wel_drop) else $error("latch kept");
  property p_lock_fall;
    $fell(persistent_protection_bit) |-> $past(write_in_progress) && $past(write_enable_latch);
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock cleared");
  property p_lock_rise;
    $rose(persistent_protection_bit) |-> $past(write_in_progress) || $past(rst) || $past(rst, 2);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock set");
  property p_frz; !$fell(freeze); endproperty
  a_frz: assert property (p_frz) else $error("freeze dropped");
  property p_keep;
    in_reset |-> $stable({persistent_protection_bit, freeze, protection_volatility_select,
                          top_bottom_protect_select, top_bottom_parameter_select});
  endproperty
  a_keep: assert property (p_keep) else $error("bit lost in reset");
  property p_bp_clr;
    (in_reset || $fell(in_reset)) && $changed(block_protect)
      |-> block_protect == 3'h0 && protection_volatility_select && !freeze;
  endproperty
  a_bp_clr: assert property (p_bp_clr) else $error("protect bits wrong");
  property p_rph;
    $fell(in_reset) |-> rph_q >= RPH_CYCLES - 1 && rph_q <= RPH_CYCLES + 1;
  endproperty
  a_rph: assert property (p_rph) else $error("recovery length");
  property p_stuck;
    program_error && write_in_progress |=> write_in_progress || !program_error;
  endproperty
  a_stuck: assert property (p_stuck) else $error("busy dropped");
  property p_oe; $rose(so_oe) |-> asp_in[pwlk_pkg::ASP_PWMODE_BIT]; endproperty
  a_oe: assert property (p_oe) else $error("read in password mode");
endmodule
bind pwlk_core pwlk_core_sva #(
  .PROG_CYCLES(PROG_CYCLES), .LOCK_CYCLES(LOCK_CYCLES), .RPH_CYCLES(RPH_CYCLES)
) chk_u (
  .clk, .rst, .asp_in, .so_oe, .write_enable_latch, .write_in_progress, .program_error,
  .persistent_protection_bit, .freeze, .block_protect, .protection_volatility_select,
  .top_bottom_protect_select, .top_bottom_parameter_select, .in_reset
);

/* bench/tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  // ****************
  // signals
  // ****************
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         cs_n, sck, si, so, so_oe, wel_set, lock_por_val, prog_fail, freeze_set, bp_wr;
  logic         volsel_in, tb_prot_in, tb_parm_in, write_enable_latch, write_in_progress;
  logic         program_error, persistent_protection_bit, freeze, in_reset, oe_seen;
  logic         protection_volatility_select, top_bottom_protect_select;
  logic         top_bottom_parameter_select;
  logic [2:0]   asp_in, bp_wdata, block_protect;
  logic [127:0] rd;
  logic [63:0]  pw_s;
  int           n_mismatch = 0;
  int           check_count = 0;
  // rows: opcode, bit count, expected {latch, busy, error, lock}
  logic [19:0]  rows [4] = '{20'ha6_08_1, 20'h06_08_9, 20'ha6_09_9, 20'ha6_08_0};
  wire  [3:0]   st_vec = {write_enable_latch, write_in_progress, program_error,
                          persistent_protection_bit};
  wire  [2:0]   straps = {protection_volatility_select, top_bottom_protect_select,
                          top_bottom_parameter_select};
  always #4 clk = ~clk;
  always @(posedge clk) if (so_oe === 1'b1) oe_seen <= 1'b1;
  pwlk_core #(.PROG_CYCLES(10), .LOCK_CYCLES(6), .RPH_CYCLES(8)) dut_u (
    .clk, .rst, .cs_n, .sck, .si, .wel_set, .asp_in, .lock_por_val, .prog_fail, .freeze_set,
    .bp_wr, .bp_wdata, .volsel_in, .tb_prot_in, .tb_parm_in, .so, .so_oe, .write_enable_latch,
    .write_in_progress, .program_error, .persistent_protection_bit, .freeze, .block_protect,
    .protection_volatility_select, .top_bottom_protect_select, .top_bottom_parameter_select,
    .in_reset
  );
  pwlk_host host_u (.clk, .cs_n, .sck, .si, .so);
  // ****************
  // tasks
  // ****************
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait: a stuck busy flag must not hang the run
  task automatic cmd(input logic [7:0] op, input int nb = 8, input logic [63:0] pw = 64'h0);
    host_u.xfer({op, pw, 64'h0}, nb, rd);
    for (int i = 0; i < 200 && (write_in_progress | in_reset) === 1'b1; i++) @(negedge clk);
  endtask
  task automatic pulse_bp();
    bp_wr = 1'b1;
    @(negedge clk) bp_wr = 1'b0;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    {wel_set, prog_fail, freeze_set, bp_wr, tb_parm_in, oe_seen} = 6'h0;
    {lock_por_val, volsel_in, tb_prot_in} = 3'h7;
    asp_in = 3'h7;
    bp_wdata = 3'h5;
    pw_s = {<<8{64'h0123_4567_89ab_cdef}};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("por", {4'h1, 3'h6}, {st_vec, straps})
    for (int k = 0; k < 4; k++) begin
      cmd(rows[k][19:12], int'(rows[k][11:4]));
      `CHK("row", rows[k][3:0], st_vec)
    end
    cmd(8'h06);
    cmd(8'he8, 72, pw_s);
    `CHK("prog", 4'h0, st_vec)
    asp_in = 3'h3;
    cmd(8'he7, 136);
    `CHK("oe", 1'b0, oe_seen)
    cmd(8'h06);
    cmd(8'he8, 72, ~pw_s);
    `CHK("ignored", 4'h8, st_vec)
    asp_in = 3'h7;
    cmd(8'he7, 136);
    `CHK("pw", {pw_s, pw_s}, rd)
    `CHK("oe_on", 1'b1, oe_seen)
    prog_fail = 1'b1;
    cmd(8'he8, 72, pw_s);
    `CHK("fail", 2'h1, {write_enable_latch, program_error})
    prog_fail = 1'b0;
    cmd(8'h30);
    `CHK("clr", 4'h0, st_vec)
    cmd(8'he9, 72, pw_s);
    `CHK("unlk", 4'h1, st_vec)
    cmd(8'he9, 72, ~pw_s);
    `CHK("miss", 4'h7, st_vec)
    pulse_bp();
    cmd(8'hf0);
    `CHK("swrst", {4'h1, 3'h0, 3'h6, 1'b0}, {st_vec, block_protect, straps, freeze})
    pulse_bp();
    freeze_set = 1'b1;
    @(negedge clk) freeze_set = 1'b0;
    cmd(8'hf0);
    `CHK("frz", 5'h17, {block_protect, freeze, persistent_protection_bit})
    lock_por_val = 1'b0;
    rst = 1'b1;
    @(negedge clk) rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("hwrst", 2'h0, {freeze, persistent_protection_bit})
    conclude();
  end
endmodule
